// File: design/dao_top.sv
// Pin level logic of a dual 14 bit converter: serial port and outputs
`timescale 1ns/1ps
`default_nettype none
module dao_top
  import dao_pkg::*;
(
  // System clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  // APB slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // Configuration pins
  input  wire logic                 config_reset_i,
  input  wire logic                 serial_shift_clk_i,
  input  wire logic [1:0]           serial_select_low_i,
  input  wire logic                 serial_shift_in_i,
  input  wire logic                 power_mode_select_1_i,
  input  wire logic                 power_mode_select_2_i,
  input  wire logic                 power_mode_select_3_i,
  output logic                      serial_readback_out_o,
  output logic                      serial_readback_out_oe_o,
  // Sample clock domain
  input  wire logic                 sample_clock_i,
  input  wire logic [SMP_W-1:0]     chan_a_sample_i,
  input  wire logic [SMP_W-1:0]     chan_b_sample_i,
  output logic      [PAIRS-1:0]     chan_a_ddr_pair_p_o,
  output logic      [PAIRS-1:0]     chan_a_ddr_pair_n_o,
  output logic      [PAIRS-1:0]     chan_b_ddr_pair_p_o,
  output logic      [PAIRS-1:0]     chan_b_ddr_pair_n_o,
  output logic      [SMP_W-1:0]     chan_a_parallel_bits_o,
  output logic      [SMP_W-1:0]     chan_b_parallel_bits_o,
  output logic                      fwd_clock_pos_o,
  output logic                      fwd_clock_neg_o,
  output logic                      single_ended_fwd_clock_o
);
  import dao_pkg::*;

  // Pin synchronisers: {reset, sclk, sel[1:0], serial_shift_in}
  logic [4:0] pin1_q, pin2_q;
  logic       sclk_prev_q;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      // Idle pin levels: select high, the rest low
      pin1_q      <= 5'h06;
      pin2_q      <= 5'h06;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      pin1_q      <= {config_reset_i, serial_shift_clk_i,
                      serial_select_low_i, serial_shift_in_i};
      pin2_q      <= pin1_q;
      sclk_prev_q <= pin2_q[3];
    end
  end

  logic       strap, sclk_s, serial_shift_in_s, fall, ser_en, lock;
  logic [1:0] sel_s;
  assign strap   = pin2_q[4];
  assign sclk_s  = pin2_q[3];
  assign sel_s   = pin2_q[2:1];
  assign serial_shift_in_s = pin2_q[0];
  assign fall    = sclk_prev_q & ~sclk_s;
  assign ser_en  = ~strap & (sel_s == SEL_LOW);

  // Register readout by serial address
  function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                        input logic [7:0] c,
                                        input logic [7:0] m);
    rd_reg = (a == SA_CTRL) ? c : (a == SA_MODE) ? m : 8'h00;
  endfunction

  // Serial port state
  logic [7:0]  ctrl_q, ctrl_d, mode_q, mode_d, rbsh_q, rbsh_d;
  logic [15:0] shreg_q, shreg_d, frames_q, frames_d;
  logic [3:0]  bitcnt_q, bitcnt_d;
  logic        sro_q, sro_d, sro_oe_q, sro_oe_d, commit;
  dao_cfg_t    cfg_q, cfg_d;

  always_comb
  begin
    ctrl_d   = ctrl_q;
    mode_d   = mode_q;
    shreg_d  = shreg_q;
    bitcnt_d = bitcnt_q;
    frames_d = frames_q;
    rbsh_d   = rbsh_q;
    commit   = 1'b0;
    if (strap)
    begin
      // Reset pin high restores defaults
      ctrl_d   = CTRL_RST;
      mode_d   = MODE_RST;
      bitcnt_d = 4'h0;
    end
    else if (!ser_en)
      bitcnt_d = 4'h0;
    else if (fall && !lock)
    begin
      shreg_d  = {shreg_q[14:0], serial_shift_in_s};
      bitcnt_d = bitcnt_q + 4'h1;
      if (bitcnt_q == ADDR_DONE)
        rbsh_d = rd_reg(shreg_d[7:0], ctrl_q, mode_q);
      else
        rbsh_d = {rbsh_q[6:0], 1'b0};
      if (bitcnt_q == LAST_BIT)
      begin
        commit   = 1'b1;
        frames_d = frames_q + 16'h0001;
        if (shreg_d[15:8] == SA_CTRL)
        begin
          if (shreg_d[8 - 8 + CTRL_SWRST])
          begin
            ctrl_d = CTRL_RST;
            mode_d = MODE_RST;
          end
          else
            ctrl_d = shreg_d[7:0];
        end
        else if (shreg_d[15:8] == SA_MODE && !ctrl_q[CTRL_RB])
          mode_d = shreg_d[7:0];
      end
    end
    // Readback pin follows the shifter only while enabled
    sro_d    = ctrl_q[CTRL_RB] & rbsh_d[7];
    sro_oe_d = ctrl_q[CTRL_RB];
    // Effective configuration: straps or registers
    if (strap)
    begin
      cfg_d.lows  = sclk_s;
      cfg_d.ddr   = sel_s[1];
      cfg_d.offb  = (sel_s == SEL_OFFB_CMOS) ||
                    (sel_s == SEL_OFFB_DDR);
      cfg_d.rb_en = 1'b0;
    end
    else
    begin
      cfg_d.lows  = mode_q[MODE_LOWS];
      cfg_d.ddr   = mode_q[MODE_DDR];
      cfg_d.offb  = mode_q[MODE_OFFB];
      cfg_d.rb_en = ctrl_q[CTRL_RB];
    end
  end

  // Serial port registers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_q   <= CTRL_RST;
      mode_q   <= MODE_RST;
      shreg_q  <= 16'h0000;
      bitcnt_q <= 4'h0;
      frames_q <= 16'h0000;
      rbsh_q   <= 8'h00;
      sro_q    <= 1'b0;
      sro_oe_q <= 1'b0;
      cfg_q    <= '0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      mode_q   <= mode_d;
      shreg_q  <= shreg_d;
      bitcnt_q <= bitcnt_d;
      frames_q <= frames_d;
      rbsh_q   <= rbsh_d;
      sro_q    <= sro_d;
      sro_oe_q <= sro_oe_d;
      cfg_q    <= cfg_d;
    end
  end
  assign serial_readback_out_o    = sro_q;
  assign serial_readback_out_oe_o = sro_oe_q;

  // APB slave: one wait state, unmapped reads zero with error
  logic        lock_q, lock_d, rdy_q, rdy_d, err_q, err_d;
  logic [31:0] rdata_q, rdata_d;
  logic        acc;
  assign acc  = psel_i & penable_i & ~rdy_q;
  assign lock = lock_q;
  always_comb
  begin
    lock_d  = lock_q;
    rdy_d   = acc;
    err_d   = 1'b0;
    rdata_d = 32'h0000_0000;
    if (acc)
    begin
      unique case (paddr_i)
        A_CTRL:
        begin
          rdata_d = {31'h0, lock_q};
          if (pwrite_i)
            lock_d = pwdata_i[APB_LOCK];
        end
        A_STATUS: rdata_d = {19'h0, strap, mode_q, cfg_q};
        A_FRAMES: rdata_d = {16'h0, frames_q};
        default:  err_d = 1'b1;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lock_q  <= 1'b0;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      lock_q  <= lock_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end
  assign pready_o  = rdy_q;
  assign pslverr_o = err_q;
  assign prdata_o  = rdata_q;

  // Sample clock side: config and power pins through two flops
  dao_cfg_t   lcfg1_q, lcfg2_q;
  logic [2:0] pm1_q, pm2_q;
  always_ff @(posedge sample_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lcfg1_q <= '0;
      lcfg2_q <= '0;
      pm1_q   <= 3'h0;
      pm2_q   <= 3'h0;
    end
    else
    begin
      lcfg1_q <= cfg_q;
      lcfg2_q <= lcfg1_q;
      pm1_q   <= {power_mode_select_1_i, power_mode_select_2_i,
                  power_mode_select_3_i};
      pm2_q   <= pm1_q;
    end
  end

  // Joint decode; unavailable codes run as normal
  dao_pmode_t pm;
  always_comb
  begin
    unique case (pm2_q)
      PM_C_PD:   pm = PM_GLOBAL_PD;
      PM_C_STBY: pm = PM_STBY_A;
      PM_C_MUX:  pm = PM_MUX;
      default:   pm = PM_NORMAL;
    endcase
  end

  // Output format: offset binary flips the sign bit
  function automatic logic [SMP_W-1:0] fmt(input logic [SMP_W-1:0] s,
                                           input logic ob);
    fmt = {s[SMP_W-1] ^ ob, s[SMP_W-2:0]};
  endfunction

  // Output state: two link cycles per sample
  logic             ph_q, ph_d, mux_q, mux_d, ck_q, ck_d;
  logic [SMP_W-1:0] ha_q, ha_d, hb_q, hb_d, pa_q, pa_d, pb_q, pb_d;
  logic [PAIRS-1:0] da_q, da_d, db_q, db_d;
  logic             dd, pd;
  assign dd = lcfg2_q.ddr;
  assign pd = (pm == PM_GLOBAL_PD);
  always_comb
  begin
    ph_d  = ~ph_q;
    mux_d = mux_q;
    ha_d  = ha_q;
    hb_d  = hb_q;
    pa_d  = pa_q;
    pb_d  = pb_q;
    da_d  = da_q;
    db_d  = db_q;
    ck_d  = ~ph_q & ~pd;
    if (!ph_q)
    begin
      mux_d = ~mux_q;
      ha_d  = (pm == PM_STBY_A || pd) ? '0 :
              fmt(chan_a_sample_i, lcfg2_q.offb);
      hb_d  = pd ? '0 : (pm == PM_MUX && !mux_q) ?
              fmt(chan_a_sample_i, lcfg2_q.offb) :
              fmt(chan_b_sample_i, lcfg2_q.offb);
      pa_d  = dd ? '0 : ha_d;
      pb_d  = dd ? '0 : hb_d;
    end
    // Even bits in the high half, odd bits in the low half
    for (int i = 0; i < PAIRS; i++)
    begin
      da_d[i] = dd & (ph_q ? ha_q[2*i+1] : ha_d[2*i]);
      db_d[i] = dd & (ph_q ? hb_q[2*i+1] : hb_d[2*i]);
    end
  end
  always_ff @(posedge sample_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ph_q  <= 1'b0;
      mux_q <= 1'b0;
      ck_q  <= 1'b0;
      ha_q  <= '0;
      hb_q  <= '0;
      pa_q  <= '0;
      pb_q  <= '0;
      da_q  <= '0;
      db_q  <= '0;
    end
    else
    begin
      ph_q  <= ph_d;
      mux_q <= mux_d;
      ck_q  <= ck_d;
      ha_q  <= ha_d;
      hb_q  <= hb_d;
      pa_q  <= pa_d;
      pb_q  <= pb_d;
      da_q  <= da_d;
      db_q  <= db_d;
    end
  end

  // Output pins, differential legs only while DDR is active
  logic dck_q, nck_q, sck_q;
  logic [PAIRS-1:0] dan_q, dbn_q;
  always_ff @(posedge sample_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dck_q <= 1'b0;
      nck_q <= 1'b0;
      sck_q <= 1'b0;
      dan_q <= '0;
      dbn_q <= '0;
    end
    else
    begin
      dck_q <= dd & ck_d;
      nck_q <= dd & ~pd & ~ck_d;
      sck_q <= ~dd & ck_d;
      dan_q <= dd ? ~da_d : '0;
      dbn_q <= dd ? ~db_d : '0;
    end
  end
  assign chan_a_ddr_pair_p_o      = da_q;
  assign chan_b_ddr_pair_p_o      = db_q;
  assign chan_a_ddr_pair_n_o      = dan_q;
  assign chan_b_ddr_pair_n_o      = dbn_q;
  assign chan_a_parallel_bits_o   = pa_q;
  assign chan_b_parallel_bits_o   = pb_q;
  assign fwd_clock_pos_o          = dck_q;
  assign fwd_clock_neg_o          = nck_q;
  assign single_ended_fwd_clock_o = sck_q;

  // Checks on the system clock
  a_rb_drive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ctrl_q[CTRL_RB] |=> sro_oe_q)
    else $error("readback pin not driven");
  a_rb_hiz: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !ctrl_q[CTRL_RB] |=> !sro_oe_q && !sro_q)
    else $error("readback pin driven while disabled");
  a_shift_fall: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ser_en && fall && !lock |=> shreg_q[0] == $past(serial_shift_in_s))
    else $error("serial bit not taken on falling edge");
  a_frame_commit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ser_en && fall && !lock && bitcnt_q == LAST_BIT
    |=> frames_q == $past(frames_q) + 16'h0001 && bitcnt_q == 4'h0)
    else $error("frame not committed on sixteenth edge");
  a_swrst_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    commit && shreg_d[15:8] == SA_CTRL && shreg_d[CTRL_SWRST]
    |=> ctrl_q == CTRL_RST && mode_q == MODE_RST)
    else $error("software reset left state behind");
  a_strap_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !ser_en |=> bitcnt_q == 4'h0)
    else $error("serial port active while disabled");
  a_strap_lows: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    strap |=> cfg_q.lows == $past(sclk_s) && cfg_q.ddr == $past(sel_s[1]))
    else $error("strap levels not applied");
  // Checks on the sample clock
  a_pd_quiet: assert property (@(posedge sample_clock_i)
    disable iff (!arst_n_i)
    pm == PM_GLOBAL_PD |=> !fwd_clock_pos_o && !single_ended_fwd_clock_o)
    else $error("clock runs in power down");
  a_odd_bits: assert property (@(posedge sample_clock_i)
    disable iff (!arst_n_i)
    ph_q && dd |=> da_q[0] == $past(ha_q[1]) && !fwd_clock_pos_o)
    else $error("odd bits not in low half");
  a_cmos_neg: assert property (@(posedge sample_clock_i)
    disable iff (!arst_n_i)
    !dd |=> !fwd_clock_neg_o && !fwd_clock_pos_o)
    else $error("negative clock pin used in parallel mode");
  c_frame: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    commit);
  c_readback: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    sro_oe_q && sro_q);
  c_strap: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    strap ##1 !strap);
  c_mux: cover property (@(posedge sample_clock_i) disable iff (!arst_n_i)
    pm == PM_MUX && dd);
endmodule
`default_nettype wire

// File: pkg/dao_pkg.sv
// Constants and types for the dual converter pin logic
package dao_pkg;
  localparam int unsigned SMP_W = 14;
  localparam int unsigned PAIRS = 7;
  // Serial port frame and register addresses
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [3:0] ADDR_DONE = 4'h7;
  localparam logic [7:0] SA_CTRL = 8'h00;
  localparam logic [7:0] SA_MODE = 8'h01;
  localparam int unsigned CTRL_RB = 0;
  localparam int unsigned CTRL_SWRST = 1;
  localparam int unsigned MODE_DDR = 0;
  localparam int unsigned MODE_OFFB = 1;
  localparam int unsigned MODE_LOWS = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h01;
  // Select pin level codes in strap mode
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_OFFB_CMOS = 2'h1;
  localparam logic [1:0] SEL_OFFB_DDR = 2'h2;
  // Power mode select codes {1,2,3}
  localparam logic [2:0] PM_C_PD = 3'h4;
  localparam logic [2:0] PM_C_STBY = 3'h5;
  localparam logic [2:0] PM_C_MUX = 3'h7;
  // APB map
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_FRAMES = 12'h008;
  localparam int unsigned APB_LOCK = 0;
  // Effective configuration carried to the link side
  typedef struct packed {
    logic ddr;
    logic offb;
    logic lows;
    logic rb_en;
  } dao_cfg_t;
  typedef enum {PM_NORMAL, PM_GLOBAL_PD, PM_STBY_A, PM_MUX} dao_pmode_t;
endpackage

// File: test/dao_far.sv
// Far side model: configuration controller and DDR receiver
`timescale 1ns/1ps
`default_nettype none
module dao_far
  import dao_pkg::*;
(
  // Clocks
  input  wire logic             clk_i,
  input  wire logic             sample_clock_i,
  // Configuration pins
  output logic                  config_reset_o,
  output logic                  shift_clk_o,
  output logic [1:0]            select_low_o,
  output logic                  shift_in_o,
  input  wire logic             readback_i,
  // Forwarded data and rebuilt samples
  input  wire logic             fwd_clock_pos_i,
  input  wire logic [PAIRS-1:0] a_pair_i,
  input  wire logic [PAIRS-1:0] b_pair_i,
  output logic [SMP_W-1:0]      a_word_o,
  output logic [SMP_W-1:0]      b_word_o
);
  logic [SMP_W-1:0] a_q;
  logic [SMP_W-1:0] b_q;
  // Idle pins: shift clock low, select high
  initial
  begin
    config_reset_o = 1'b0;
    shift_clk_o = 1'b0;
    select_low_o = 2'h3;
    shift_in_o = 1'b0;
  end
  // Wait whole system clocks
  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Reset pin pulse before serial use
  task automatic reset_pulse();
    config_reset_o <= 1'b1;
    pause(4);
    config_reset_o <= 1'b0;
    pause(4);
  endtask
  // Static strap levels
  task automatic strap(input logic lvl, input logic [1:0] s);
    config_reset_o <= 1'b1;
    shift_clk_o <= lvl;
    select_low_o <= s;
    pause(4);
  endtask
  // Shift nb bits MSB first, collect readback bits
  task automatic send(input logic [31:0] bits, input int nb,
                      output logic [7:0] rb);
    select_low_o <= 2'h0;
    pause(4);
    for (int i = 0; i < nb; i++)
    begin
      shift_in_o <= bits[nb-1-i];
      shift_clk_o <= 1'b1;
      pause(4);
      if (i % 16 >= 8)
        rb = {rb[6:0], readback_i};
      shift_clk_o <= 1'b0;
      pause(4);
    end
    shift_in_o <= 1'b0;
    select_low_o <= 2'h3;
    pause(4);
  endtask
  // Capture both halves mid link cycle, rebuild samples
  always @(negedge sample_clock_i)
  begin
    for (int i = 0; i < PAIRS; i++)
    begin
      a_q[2*i+(fwd_clock_pos_i ? 0 : 1)] = a_pair_i[i];
      b_q[2*i+(fwd_clock_pos_i ? 0 : 1)] = b_pair_i[i];
    end
    if (!fwd_clock_pos_i)
    begin
      a_word_o <= a_q;
      b_word_o <= b_q;
    end
  end
endmodule
`default_nettype wire

// File: test/dao_top_test.sv
// Self-checking bench for the dual converter pin logic
`timescale 1ns/1ps
`default_nettype none
module dao_top_test;
  import dao_pkg::*;
  logic             clk_i, arst_n_i, psel_i, penable_i, pwrite_i;
  logic [11:0]      paddr_i;
  logic [31:0]      pwdata_i, prdata_o, q;
  logic             pready_o, pslverr_o, err, cfg_rst, sclk, sdin;
  logic             rb, rb_oe, smp_clk, fp, fn, fse, c0;
  logic [1:0]       sel, md;
  logic [2:0]       pm, m, pc;
  logic [7:0]       rbv;
  logic [15:0]      f0;
  logic [SMP_W-1:0] sa, sb, pa, pb, wa, wb;
  logic [PAIRS-1:0] ap, an, bp, bn;
  int               failures, checked, seed;
  // Power codes exercised: decoded ones and two unavailable ones
  localparam logic [14:0] PCODES = {PM_C_PD, PM_C_STBY, PM_C_MUX,
                                    3'h2, 3'h1};
  wire logic        rb_pin;
  assign rb_pin = rb_oe ? rb : 1'bz;
  dao_top dao_top_inst (
    .clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .config_reset_i(cfg_rst), .serial_shift_clk_i(sclk),
    .serial_select_low_i(sel), .serial_shift_in_i(sdin),
    .power_mode_select_1_i(pm[2]), .power_mode_select_2_i(pm[1]),
    .power_mode_select_3_i(pm[0]), .serial_readback_out_o(rb),
    .serial_readback_out_oe_o(rb_oe), .sample_clock_i(smp_clk),
    .chan_a_sample_i(sa), .chan_b_sample_i(sb),
    .chan_a_ddr_pair_p_o(ap), .chan_a_ddr_pair_n_o(an),
    .chan_b_ddr_pair_p_o(bp), .chan_b_ddr_pair_n_o(bn),
    .chan_a_parallel_bits_o(pa), .chan_b_parallel_bits_o(pb),
    .fwd_clock_pos_o(fp), .fwd_clock_neg_o(fn),
    .single_ended_fwd_clock_o(fse)
  );
  dao_far dao_far_inst (
    .clk_i, .sample_clock_i(smp_clk), .config_reset_o(cfg_rst),
    .shift_clk_o(sclk), .select_low_o(sel), .shift_in_o(sdin),
    .readback_i(rb_pin), .fwd_clock_pos_i(fp), .a_pair_i(ap),
    .b_pair_i(bp), .a_word_o(wa), .b_word_o(wb)
  );
  // System clock, 25 ns
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Link clock, 64 ns, own phase
  initial
  begin
    smp_clk = 1'b0;
    #3.3;
    forever #32 smp_clk = ~smp_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, result in q and err
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1)
    begin
      failures++;
      report_and_stop();
    end
    @(posedge clk_i);
  endtask
  // Effective configuration seen in the status word
  task automatic status(input logic [2:0] mm, input logic rbe,
                        input logic st);
    apb(1'b0, A_STATUS, 32'h0);
    chk(q & 32'h0000100F, {19'h0, st, 8'h0, mm[0], mm[1], mm[2], rbe});
  endtask
  // Committed frame count grows by dn
  task automatic count(input logic [15:0] dn);
    f0 = f0 + dn;
    apb(1'b0, A_FRAMES, 32'h0);
    chk(32'(q[15:0]), 32'(f0));
  endtask
  // Serial frames then settle time
  task automatic frame(input logic [31:0] bits, input int nb);
    dao_far_inst.send(bits, nb, rbv);
    repeat (8) @(posedge clk_i);
  endtask
  // Random samples checked at the output pins
  task automatic samples(input logic [2:0] code, input logic [2:0] mm);
    logic [SMP_W-1:0] ea, eb;
    for (int k = 0; k < 3; k++)
    begin
      sa <= SMP_W'($urandom);
      sb <= SMP_W'($urandom);
      repeat (40) @(posedge clk_i);
      ea = (code == PM_C_PD || code == PM_C_STBY) ? '0 : sa ^ {mm[1], 13'h0};
      eb = (code == PM_C_PD) ? '0 : sb ^ {mm[1], 13'h0};
      @(negedge smp_clk);
      c0 = mm[0] ? fp : fse;
      @(negedge smp_clk);
      if (mm[0])
      begin
        chk(32'({wa, wb}), 32'({ea, eb}));
        chk(32'({an, bn, fn}), 32'({~ap, ~bp, ~fp}));
        chk(32'({fp ^ c0, fse, pa}), 32'h8000);
      end
      else
      begin
        if (code != PM_C_MUX)
          chk(32'(pa), 32'(ea));
        chk(32'(pb === eb || (code == PM_C_MUX && pb === ea)), 1);
        chk(32'({fse ^ c0, fp, fn}), {29'h0, code != PM_C_PD, 2'h0});
      end
    end
  endtask
  // Final verdict
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {psel_i, penable_i, pwrite_i, arst_n_i} = 4'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pm = 3'h0;
    sa = '0;
    sb = '0;
    f0 = 16'h0;
    failures = 0;
    checked = 0;
    seed = $urandom(95);
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'(rb_oe), 0);
    dao_far_inst.reset_pulse();
    status(3'h1, 1'b0, 1'b0);
    count(0);
    m = 3'($urandom);
    frame({16'h0, SA_MODE, 5'h0, m}, 16);
    status(m, 1'b0, 1'b0);
    count(1);
    m = 3'($urandom);
    frame({SA_MODE, 8'h05, SA_MODE, 5'h0, m}, 32);
    status(m, 1'b0, 1'b0);
    count(2);
    frame({24'h0, SA_MODE}, 8);
    count(0);
    // Lock over APB: frames ignored, lock reads back
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b0, A_CTRL, 32'h0);
    chk(q, 32'h1);
    frame({16'h0, SA_MODE, 8'h00}, 16);
    count(0);
    status(m, 1'b0, 1'b0);
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b0, A_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk({q[30:0], err}, 32'h1);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk(32'(err), 1);
    frame({16'h0, SA_CTRL, 8'h01}, 16);
    chk(32'(rb_oe), 1);
    frame({16'h0, SA_MODE, 8'hFF}, 16);
    chk(32'(rbv), {29'h0, m});
    status(m, 1'b1, 1'b0);
    frame({16'h0, SA_CTRL, 8'h02}, 16);
    status(3'h1, 1'b0, 1'b0);
    chk(32'(rb_oe), 0);
    // Modes 3, 1, 0: last one leaves parallel twos complement
    for (int i = 0; i < 3; i++)
    begin
      md = 2'(3 >> i);
      frame({16'h0, SA_MODE, 6'h0, md}, 16);
      samples(3'h0, {1'b0, md});
    end
    for (int i = 0; i < 5; i++)
    begin
      pc = PCODES[3*i +: 3];
      pm <= pc;
      samples(pc, 3'h0);
    end
    pm <= 3'h0;
    for (int s = 0; s < 4; s++)
    begin
      m[2] = 1'($urandom);
      dao_far_inst.strap(m[2], 2'(s));
      repeat (20) @(posedge clk_i);
      status({m[2], s[0] ^ s[1], s[1]}, 1'b0, 1'b1);
      chk(32'(rb_oe), 0);
    end
    // Second reset in mid run: counter cleared, straps reapplied
    arst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    f0 = 16'h0;
    count(0);
    status({m[2], 1'b0, 1'b1}, 1'b0, 1'b1);
    chk(32'(rb_oe), 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
